// ===== sfspi_pkg.sv
// Shared constants and carrier types for the serial flash pin front end
package sfspi_pkg;
	// ----------------------------------------------------------------
	// Widths and steps
	// ----------------------------------------------------------------
	localparam int unsigned BYTE_W     = 8;
	localparam int unsigned FIFO_DEPTH = 8;
	localparam int unsigned BITCNT_W   = 3;
	localparam logic [BITCNT_W-1:0] BITCNT_ZERO = 3'h0;
	localparam logic [BITCNT_W-1:0] BITCNT_LAST = 3'h7;
	localparam logic [BITCNT_W-1:0] STEP_SINGLE = 3'h1;
	localparam logic [BITCNT_W-1:0] STEP_DUAL   = 3'h2;
	localparam logic [BITCNT_W-1:0] LEFT_SINGLE = 3'h7;
	localparam logic [BITCNT_W-1:0] LEFT_DUAL   = 3'h6;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic cs_n;
		logic sck;
		logic si;
		logic pause_n;
		logic wp_n;
	} sfspi_pins_t;

	localparam sfspi_pins_t PINS_IDLE = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0,
		pause_n: 1'b1, wp_n: 1'b1};

	typedef struct packed {
		logic so;
		logic so_oe;
		logic dual_low;
		logic dual_low_oe;
	} sfspi_drive_t;
endpackage

// ===== sfspi_front.sv
// Serial flash pin front end with receive FIFO
`timescale 1ns/1ps
`default_nettype none

module sfspi_fifo #(
	parameter int unsigned W = 8,
	parameter int unsigned D = 8
) (
	// Clock and reset
	input  wire logic         i_sys_clk,
	input  wire logic         i_rst_n,
	// Fill side
	input  wire logic         i_in_valid,
	input  wire logic [W-1:0] i_in_data,
	output logic              o_in_ready,
	// Drain side
	output logic              o_out_valid,
	output logic [W-1:0]      o_out_data,
	input  wire logic         i_out_ready
);
	localparam int unsigned AW = (D > 1) ? $clog2(D) : 1;
	localparam logic [AW:0] CNT_FULL = (AW+1)'(D);

	logic [W-1:0] mem_q [D];
	logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
	logic [AW:0]   cnt_q, cnt_d;
	logic          push, pop;

	assign o_in_ready  = (cnt_q != CNT_FULL);
	assign o_out_valid = (cnt_q != '0);
	assign o_out_data  = mem_q[rp_q];
	assign push = i_in_valid & o_in_ready;
	assign pop  = o_out_valid & i_out_ready;

	always_comb begin
		wp_d  = push ? ((wp_q == AW'(D - 1)) ? '0 : wp_q + AW'(1)) : wp_q;
		rp_d  = pop ? ((rp_q == AW'(D - 1)) ? '0 : rp_q + AW'(1)) : rp_q;
		cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			wp_q  <= wp_d;
			rp_q  <= rp_d;
			cnt_q <= cnt_d;
		end
	end

	// Storage carries no reset; contents are gated by the count
	always_ff @(posedge i_sys_clk) begin
		if (push) begin
			mem_q[wp_q] <= i_in_data;
		end
	end
endmodule

module sfspi_front
	import sfspi_pkg::*;
(
	// Clock and reset
	input  wire logic              i_sys_clk,
	input  wire logic              i_rst_n,
	// Serial pins
	input  wire logic              i_cs_n,
	input  wire logic              i_sck,
	input  wire logic              i_dual_line_low,
	input  wire logic              i_pause_n,
	input  wire logic              i_wp_n,
	output logic                   o_dual_line_high,
	output logic                   o_dual_line_high_oe,
	output logic                   o_dual_line_low,
	output logic                   o_dual_line_low_oe,
	// Core status
	input  wire logic              i_busy,
	output logic                   o_selected,
	output logic                   o_standby,
	output logic                   o_paused,
	output logic                   o_lock_enable,
	output logic                   o_rx_overrun,
	// Received bytes
	output logic                   o_rx_valid,
	output logic [BYTE_W-1:0]      o_rx_data,
	input  wire logic              i_rx_ready,
	// Read data to send
	input  wire logic              i_tx_enable,
	input  wire logic              i_tx_dual,
	input  wire logic              i_tx_valid,
	input  wire logic [BYTE_W-1:0] i_tx_data,
	output logic                   o_tx_ready
);
	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	sfspi_pins_t raw, s1_q, s2_q, s3_q, flt_q, flt_d;

	assign raw = '{cs_n: i_cs_n, sck: i_sck, si: i_dual_line_low,
		pause_n: i_pause_n, wp_n: i_wp_n};

	// A bit moves only once stages two and three agree
	always_comb begin
		flt_d = flt_q;
		for (int i = 0; i < $bits(sfspi_pins_t); i++) begin
			if (s2_q[i] == s3_q[i]) begin
				flt_d[i] = s3_q[i];
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s1_q  <= PINS_IDLE;
			s2_q  <= PINS_IDLE;
			s3_q  <= PINS_IDLE;
			flt_q <= PINS_IDLE;
		end else begin
			s1_q  <= raw;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			flt_q <= flt_d;
		end
	end

	// ----------------------------------------------------------------
	// Shift state
	// ----------------------------------------------------------------
	logic              sel, sck_rise, sck_fall, cs_fall;
	logic              pause_q, pause_d, rose_q, rose_d, ovr_q, ovr_d;
	logic [BYTE_W-1:0] rx_sh_q, rx_sh_d, tx_sh_q, tx_sh_d;
	logic [BITCNT_W-1:0] rx_cnt_q, rx_cnt_d, tx_left_q, tx_left_d;
	logic              push, fifo_ready;
	sfspi_drive_t      drv_q, drv_d;

	assign sel      = !flt_q.cs_n;
	assign cs_fall  = flt_q.cs_n & !flt_d.cs_n;
	assign sck_rise = !flt_q.sck & flt_d.sck;
	assign sck_fall = flt_q.sck & !flt_d.sck;

	always_comb begin
		pause_d   = pause_q;
		rose_d    = rose_q;
		ovr_d     = ovr_q;
		rx_sh_d   = rx_sh_q;
		rx_cnt_d  = rx_cnt_q;
		tx_sh_d   = tx_sh_q;
		tx_left_d = tx_left_q;
		drv_d     = drv_q;
		push      = 1'b0;
		o_tx_ready = 1'b0;
		if (!sel) begin
			// Deselect drops partial bytes and floats both lines
			pause_d   = 1'b0;
			rose_d    = 1'b0;
			rx_cnt_d  = BITCNT_ZERO;
			tx_left_d = BITCNT_ZERO;
			drv_d     = '0;
		end else if (cs_fall) begin
			// Idle level of SCK here may be low or high
			rose_d = 1'b0;
		end else if (pause_q) begin
			// Release on pause high; SCK and SI ignored meanwhile
			pause_d = !flt_q.pause_n;
			drv_d.so_oe       = 1'b0;
			drv_d.dual_low_oe = 1'b0;
		end else if (!flt_q.pause_n && !flt_q.sck) begin
			pause_d = 1'b1;
			drv_d.so_oe       = 1'b0;
			drv_d.dual_low_oe = 1'b0;
		end else begin
			if (sck_rise) begin
				// Input bits enter at the bottom, first bit ends on top
				rose_d   = 1'b1;
				rx_sh_d  = {rx_sh_q[BYTE_W-2:0], flt_d.si};
				rx_cnt_d = rx_cnt_q + STEP_SINGLE;
				if (rx_cnt_q == BITCNT_LAST && !i_tx_enable) begin
					push = 1'b1;
					// FIFO full: byte dropped, flagged until the next select falls
					ovr_d = ovr_q | !fifo_ready;
				end
			end
			// Mode 3 opens with a fall before any rise; skip it
			if (sck_fall && rose_q && i_tx_enable) begin
				// Outputs change only on the falling edge
				if (tx_left_q == BITCNT_ZERO) begin
					o_tx_ready = 1'b1;
					tx_sh_d    = i_tx_valid ? i_tx_data : '0;
					tx_left_d  = i_tx_dual ? LEFT_DUAL : LEFT_SINGLE;
				end else begin
					tx_sh_d   = i_tx_dual ? {tx_sh_q[BYTE_W-3:0], 2'b00}
						: {tx_sh_q[BYTE_W-2:0], 1'b0};
					tx_left_d = tx_left_q - (i_tx_dual ? STEP_DUAL : STEP_SINGLE);
				end
				// Upper bit of a pair on the high line
				drv_d.so          = tx_sh_d[BYTE_W-1];
				drv_d.so_oe       = 1'b1;
				drv_d.dual_low    = i_tx_dual & tx_sh_d[BYTE_W-2];
				drv_d.dual_low_oe = i_tx_dual;
			end else if (!i_tx_enable) begin
				drv_d.so_oe       = 1'b0;
				drv_d.dual_low_oe = 1'b0;
				tx_left_d         = BITCNT_ZERO;
			end
		end
		if (cs_fall) begin
			ovr_d = 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pause_q   <= 1'b0;
			rose_q    <= 1'b0;
			ovr_q     <= 1'b0;
			rx_sh_q   <= '0;
			rx_cnt_q  <= BITCNT_ZERO;
			tx_sh_q   <= '0;
			tx_left_q <= BITCNT_ZERO;
			drv_q     <= '0;
		end else begin
			pause_q   <= pause_d;
			rose_q    <= rose_d;
			ovr_q     <= ovr_d;
			rx_sh_q   <= rx_sh_d;
			rx_cnt_q  <= rx_cnt_d;
			tx_sh_q   <= tx_sh_d;
			tx_left_q <= tx_left_d;
			drv_q     <= drv_d;
		end
	end

	// ----------------------------------------------------------------
	// Receive buffer
	// ----------------------------------------------------------------
	sfspi_fifo #(
		.W (BYTE_W),
		.D (FIFO_DEPTH)
	) u_rx_fifo (
		.i_sys_clk   (i_sys_clk),
		.i_rst_n     (i_rst_n),
		.i_in_valid  (push),
		.i_in_data   ({rx_sh_q[BYTE_W-2:0], flt_d.si}),
		.o_in_ready  (fifo_ready),
		.o_out_valid (o_rx_valid),
		.o_out_data  (o_rx_data),
		.i_out_ready (i_rx_ready)
	);

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign o_dual_line_high    = drv_q.so;
	assign o_dual_line_high_oe = drv_q.so_oe;
	assign o_dual_line_low     = drv_q.dual_low;
	assign o_dual_line_low_oe  = drv_q.dual_low_oe;
	assign o_selected          = sel;
	assign o_paused            = pause_q;
	assign o_rx_overrun        = ovr_q;
	// Busy core holds off standby after deselect
	assign o_standby           = !sel & !i_busy;
	// Pin idles high: the bench drives it high by default
	assign o_lock_enable       = !flt_q.wp_n;
endmodule

`default_nettype wire

// ===== sfspi_host_model.sv
// Host controller model driving the serial pins
`timescale 1ns/1ps
`default_nettype none
module sfspi_host_model (
	output logic      cs_n,
	output logic      sck,
	output logic      si,
	input  wire logic so,
	input  wire logic si_in
);
	initial begin
		cs_n = 1'b1;
		sck  = 1'b0;
		si   = 1'b0;
	end
	// Clock parked at its idle level before select falls
	task automatic open_frame(input logic idle_hi);
		sck = idle_hi;
		#200 cs_n = 1'b0;
		#200;
	endtask
	task automatic close_frame(input logic idle_hi);
		if (!idle_hi) sck = 1'b0;
		#200 cs_n = 1'b1;
		#400;
	endtask
	task automatic xfer(input logic [7:0] tx, input logic dual, output logic [7:0] rx);
		for (int i = 0; i < (dual ? 4 : 8); i++) begin
			sck = 1'b0;
			// Released line toggles so a stale bit never looks valid
			si = dual ? ~si : tx[7-i];
			#200 sck = 1'b1;
			rx = dual ? {rx[5:0], so, si_in} : {rx[6:0], so};
			#200;
		end
	endtask
endmodule
`default_nettype wire

// ===== sfspi_front_monitor.sv
// Port checker for the serial flash pin front end
`timescale 1ns/1ps
`default_nettype none
module sfspi_front_monitor (
	input wire logic i_sys_clk, i_rst_n, i_cs_n, i_sck, i_wp_n, i_busy, i_tx_enable, i_tx_dual,
	input wire logic o_dual_line_high, o_dual_line_high_oe, o_dual_line_low_oe, o_selected,
	input wire logic o_standby, o_paused, o_lock_enable, o_tx_ready, o_rx_valid
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	// Pin filter lags up to four clocks, so eight give margin
	deselect_float_a: assert property (
		i_cs_n [*8] |-> !o_selected && !o_dual_line_high_oe && !o_dual_line_low_oe)
		else $error("drive while deselected");
	standby_busy_a: assert property (
		$rose(o_standby) |-> !i_busy && $past(i_cs_n, 3))
		else $error("standby wrong");
	rx_select_a: assert property ($rose(o_rx_valid) |-> $past(o_selected))
		else $error("byte taken while deselected");
	pause_float_a: assert property (
		o_paused [*2] |-> !o_dual_line_high_oe && !o_dual_line_low_oe)
		else $error("drive while paused");
	pause_entry_a: assert property ($rose(o_paused) |-> o_selected && !i_sck)
		else $error("pause entered wrongly");
	load_fall_a: assert property (o_tx_ready |-> !i_sck && i_tx_enable)
		else $error("byte loaded off a fall");
	// Filter delay puts the fall that moved the bit three clocks back
	shift_fall_a: assert property (
		o_dual_line_high_oe && $changed(o_dual_line_high) |-> !$past(i_sck, 3))
		else $error("output moved with clock high");
	dual_pair_a: assert property (
		o_dual_line_low_oe |-> i_tx_dual && o_dual_line_high_oe)
		else $error("low line driven alone");
	lock_on_a: assert property (!i_wp_n [*6] |-> o_lock_enable)
		else $error("lock not set");
endmodule
bind sfspi_front sfspi_front_monitor mon (.*);
`default_nettype wire

// ===== test_sfspi_front.sv
// Self-checking bench for the serial flash pin front end
`timescale 1ns/1ps
`default_nettype none
module test_sfspi_front
	import sfspi_pkg::*;
;
	logic i_sys_clk = 1'b0, i_rst_n = 1'b0, i_pause_n = 1'b1, i_wp_n = 1'b1, i_busy = 1'b0;
	logic i_rx_ready = 1'b0, i_tx_enable = 1'b0, i_tx_dual = 1'b0, i_tx_valid = 1'b1;
	logic [BYTE_W-1:0] i_tx_data = 8'h00, o_rx_data;
	logic h_cs_n, h_sck, h_si, si_w, so_w, o_dual_line_high, o_dual_line_high_oe;
	logic o_dual_line_low, o_dual_line_low_oe, o_selected, o_standby, o_paused;
	logic o_lock_enable, o_rx_overrun, o_rx_valid, o_tx_ready;
	int failures = 0, check_count = 0;
	int loads = 0;
	always #25 i_sys_clk = ~i_sys_clk;
	// Byte loads seen by the core side
	always @(posedge i_sys_clk) begin
		if (o_tx_ready === 1'b1) loads <= loads + 1;
	end
	assign si_w = o_dual_line_low_oe ? o_dual_line_low : h_si;
	assign so_w = o_dual_line_high_oe ? o_dual_line_high : ~o_dual_line_high;
	sfspi_front dut (.i_sys_clk, .i_rst_n, .i_cs_n(h_cs_n), .i_sck(h_sck), .i_dual_line_low(si_w),
		.i_pause_n, .i_wp_n, .o_dual_line_high, .o_dual_line_high_oe, .o_dual_line_low,
		.o_dual_line_low_oe, .i_busy, .o_selected, .o_standby, .o_paused, .o_lock_enable,
		.o_rx_overrun, .o_rx_valid, .o_rx_data, .i_rx_ready, .i_tx_enable, .i_tx_dual,
		.i_tx_valid, .i_tx_data, .o_tx_ready);
	sfspi_host_model host (.cs_n(h_cs_n), .sck(h_sck), .si(h_si), .so(so_w), .si_in(si_w));
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] act);
		check_count++;
		if (act !== exp) begin
			failures++;
			$display("FAIL %s expected %h seen %h", what, exp, act);
		end
	endtask
	task automatic pop(input logic [7:0] exp);
		int n = 0;
		while (o_rx_valid !== 1'b1 && n < 50) begin
			@(negedge i_sys_clk);
			n++;
		end
		check("rx valid", 8'h01, {7'h0, o_rx_valid});
		check("rx byte", exp, o_rx_data);
		i_rx_ready = 1'b1;
		// Posedge first: ready may rise within a negedge time step
		@(posedge i_sys_clk);
		@(negedge i_sys_clk);
		i_rx_ready = 1'b0;
	endtask
	task automatic t_rx();
		logic [7:0] r;
		host.xfer(8'ha5, 1'b0, r);
		check("idle capture", 8'h00, {7'h0, o_rx_valid});
		host.open_frame(1'b0);
		host.xfer(8'ha5, 1'b0, r);
		host.xfer(8'h3c, 1'b0, r);
		host.close_frame(1'b0);
		pop(8'ha5);
		pop(8'h3c);
		$display("test rx done");
	endtask
	task automatic t_read();
		logic [7:0] r;
		logic [7:0] exp;
		int base;
		// Single mode 0, dual mode 3, then single mode 3 with no byte ready
		for (int k = 0; k < 3; k++) begin
			@(negedge i_sys_clk);
			i_tx_dual = (k == 1);
			i_tx_valid = (k != 2);
			i_tx_data = (k == 1) ? 8'h9b : ((k == 2) ? 8'h5e : 8'hc6);
			exp = (k == 2) ? 8'h00 : i_tx_data;
			host.open_frame(k != 0);
			host.xfer(8'h0b, 1'b0, r);
			@(negedge i_sys_clk);
			i_tx_enable = 1'b1;
			base = loads;
			host.xfer(8'hff, k == 1, r);
			check("read byte", exp, r);
			check("byte loads", 8'h01, 8'(loads - base));
			host.close_frame(k != 0);
			@(negedge i_sys_clk);
			i_tx_enable = 1'b0;
			repeat (10) @(negedge i_sys_clk);
			check("oe", 8'h00, {6'h0, o_dual_line_high_oe, o_dual_line_low_oe});
			check("standby", 8'h01, {7'h0, o_standby});
			pop(8'h0b);
		end
		$display("test read done");
	endtask
	task automatic t_fifo();
		logic [7:0] r;
		host.open_frame(1'b0);
		for (int i = 0; i < 9; i++) host.xfer(8'(i + 16), 1'b0, r);
		host.close_frame(1'b0);
		check("overrun", 8'h01, {7'h0, o_rx_overrun});
		for (int i = 0; i < 8; i++) pop(8'(i + 16));
		check("drained", 8'h00, {7'h0, o_rx_valid});
		$display("test fifo done");
	endtask
	task automatic t_pins();
		logic [7:0] r;
		@(negedge i_sys_clk);
		i_busy = 1'b1;
		i_wp_n = 1'b0;
		repeat (8) @(negedge i_sys_clk);
		check("busy standby", 8'h00, {7'h0, o_standby});
		check("lock", 8'h01, {7'h0, o_lock_enable});
		host.open_frame(1'b0);
		check("selected", 8'h01, {7'h0, o_selected});
		@(negedge i_sys_clk);
		i_pause_n = 1'b0;
		repeat (8) @(negedge i_sys_clk);
		check("paused", 8'h01, {7'h0, o_paused});
		host.xfer(8'h5a, 1'b0, r);
		@(negedge i_sys_clk);
		i_pause_n = 1'b1;
		host.close_frame(1'b0);
		@(negedge i_sys_clk);
		i_busy = 1'b0;
		i_wp_n = 1'b1;
		repeat (10) @(negedge i_sys_clk);
		check("paused byte", 8'h00, {7'h0, o_rx_valid});
		check("unlock", 8'h00, {7'h0, o_lock_enable});
		check("idle standby", 8'h01, {7'h0, o_standby});
		$display("test pins done");
	endtask
	task automatic stop_test();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		#400000;
		failures++;
		stop_test();
	end
	initial begin
		repeat (5) @(negedge i_sys_clk);
		i_rst_n = 1'b1;
		repeat (6) @(negedge i_sys_clk);
		t_rx();
		t_read();
		t_fifo();
		t_pins();
		stop_test();
	end
endmodule
`default_nettype wire
